// ===== logic/rf_cfg_pkg.sv
// Package with constants and types for the radio configuration bank
package rf_cfg_pkg;
  // Parameter selectors on the command port
  localparam logic [3:0] SEL_CHANNEL_MASK = 4'h0;
  localparam logic [3:0] SEL_SURVEY_EXP = 4'h1;
  localparam logic [3:0] SEL_UPPER_ID = 4'h2;
  localparam logic [3:0] SEL_LOWER_ID = 4'h3;
  localparam logic [3:0] SEL_LOW_POWER = 4'h4;
  localparam logic [3:0] SEL_DOZE = 4'h5;
  localparam logic [3:0] SEL_IDLE_WAIT = 4'h6;
  localparam logic [3:0] SEL_FW_REV = 4'h7;
  localparam logic [3:0] SEL_PWM_HOLD = 4'h8;
  // Values after reset, limits and special codes
  localparam logic [15:0] RST_CHANNEL_MASK = 16'h1FFE;
  localparam logic [7:0] RST_SURVEY_EXP = 8'h04;
  localparam logic [7:0] RST_LOW_POWER = 8'h00;
  localparam logic [15:0] RST_DOZE = 16'h0000;
  localparam logic [15:0] RST_IDLE_WAIT = 16'h1388;
  localparam logic [7:0] RST_PWM_HOLD = 8'h28;
  localparam logic [7:0] PWM_HOLD_FOREVER = 8'hFF;
  localparam logic [15:0] DOZE_MAX = 16'h68B0;
  localparam logic [7:0] SURVEY_EXP_MAX = 8'h0F;
  localparam logic [7:0] LOW_POWER_MAX = 8'h05;
  localparam logic [7:0] LOW_POWER_RSVD = 8'h03;
  localparam logic [7:0] LOW_POWER_CYC = 8'h04;
  localparam logic [7:0] LOW_POWER_CYC_PIN = 8'h05;
  // Timing, clock at 100 MHz
  localparam int CLK_NS = 10;
  localparam int SLOT_US = 15360;
  localparam int SLOT_CYC = SLOT_US * 1000 / CLK_NS;
  localparam int MS_UNIT = 1;
  localparam int MS_CYC = MS_UNIT * 1000000 / CLK_NS;
  localparam int HOLD_UNIT_MS = 100;
  localparam int HOLD_CYC = HOLD_UNIT_MS * MS_CYC;
  localparam int PWM_PERIOD_US = 8320;
  localparam int PWM_STEPS = 40;
  localparam int PWM_STEP_CYC = PWM_PERIOD_US * 1000 / CLK_NS / PWM_STEPS;
  // Strength to duty formula, offset and slope scaled by ten, divisor by a hundred
  localparam int DUTY_OFS_X10 = 2950;
  localparam int DUTY_SLOPE_X10 = 175;
  localparam int DUTY_DIV_X100 = 1024;
  // Command port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] sel;
    logic [31:0] data;
  } cfg_req_t;
  // Sleep states
  typedef enum logic [2:0] {
    SLP_AWAKE = 3'b001,
    SLP_DOZE = 3'b010,
    SLP_CHECK = 3'b100
  } sleep_state_t;
endpackage : rf_cfg_pkg

// ===== logic/rf_module_config_params.sv
// Configuration bank, signal strength meter and sleep timing of the module
//
// Overview of operation
// - Duty equals offset plus slope per dB, scaled
// - Nonzero timeout shows strength, then zero duty
// - Zero duty after power-up until first packet
// - All-ones timeout never expires the meter
// - Mask bit n enables channel 0x0B plus n
// - Mask applies to all scan kinds
// - Scan lasts channels times 2^exp times slot
// - Exponent times coordinator relocation scans too
// - Unique address read-only as two halves
// - Decode low-power choice 0 to 5
// - Cyclic sleep dozes interval, checks, redozes
// - Interval sets cyclic doze and indirect hold; zero means direct
// - Coordinator drops indirect after 2.5 intervals
// - Cyclic choices doze after idle wait in ms
// - Version word: release digits, variant, revision
// - Commit saves parameters; power-on reloads them
// - Meter period fixed, forty duty steps
module rf_module_config_params
  import rf_cfg_pkg::*;
#(
  parameter logic [31:0] UPPER_ID = 32'h0000_0001, // Arbitrary value
  parameter logic [31:0] LOWER_ID = 32'h0000_0002, // Arbitrary value
  parameter logic [15:0] FW_REV = 16'h1080, // Arbitrary value
  parameter int SLOT_CYCLES = SLOT_CYC,
  parameter int MS_CYCLES = MS_CYC,
  parameter int HOLD_CYCLES = HOLD_CYC,
  parameter int STEP_CYCLES = PWM_STEP_CYC
)
(
  input wire logic clock,
  input wire logic rst,
  input wire cfg_req_t req,         // Read or write of one parameter
  input wire logic commit,          // Save parameters to store
  output logic [31:0] rd_data,      // Read answer
  output logic rd_valid,            // Read answer strobe
  output logic [95:0] save_image,   // Image written to store
  output logic save_strobe,         // Store write pulse
  input wire logic [95:0] load_image, // Image held in store
  input wire logic load_valid,      // Store holds a saved image
  input wire logic pkt_rx,          // Packet received pulse
  input wire logic [6:0] pkt_margin_db, // Its dB above sensitivity
  output logic pwm_out,             // Signal strength meter
  input wire logic scan_start,      // Any scan request
  output logic [4:0] scan_channel,  // Channel being scanned
  output logic scan_busy,           // Scan in progress
  output logic scan_done,           // Scan finished pulse
  input wire logic activity,        // Serial or radio traffic
  input wire logic data_pending,    // Data seen at wake check
  input wire logic is_coordinator,  // Coordinator role
  input wire logic indirect_start,  // Indirect message queued
  output logic indirect_drop,       // Indirect message expired
  output logic direct_delivery,     // Interval zero: direct
  output logic asleep,              // Doze state
  output logic pin_sleep_enable,    // Choice 1 or 2
  output logic pin_wake_enable      // Choice 5
);
  logic [15:0] mask_reg, mask_next;       // Channel mask
  logic [7:0] exp_reg, exp_next;          // Survey exponent
  logic [7:0] lp_reg, lp_next;            // Low-power choice
  logic [15:0] doze_reg, doze_next;       // Doze interval
  logic [15:0] idle_reg, idle_next;       // Idle wait
  logic [7:0] hold_reg, hold_next;        // Meter timeout
  logic loaded_reg, loaded_next;          // Image loaded once
  logic [31:0] rdd_reg, rdd_next;
  logic rdv_reg, rdv_next;
  logic cyclic;

  // Parameter writes, reads and power-on reload
  always_comb
  begin
    mask_next = mask_reg;
    exp_next = exp_reg;
    lp_next = lp_reg;
    doze_next = doze_reg;
    idle_next = idle_reg;
    hold_next = hold_reg;
    loaded_next = 1'b1;
    rdv_next = req.rd;
    rdd_next = 32'h0000_0000;
    if (!loaded_reg && load_valid)
    begin
      // Reload last committed values
      mask_next = load_image[15:0];
      exp_next = load_image[23:16];
      lp_next = load_image[31:24];
      doze_next = load_image[47:32];
      idle_next = load_image[63:48];
      hold_next = load_image[71:64];
    end
    else if (req.wr)
    begin
      case (req.sel)
        SEL_CHANNEL_MASK: mask_next = req.data[15:0];
        SEL_SURVEY_EXP:
          if (req.data[7:0] <= SURVEY_EXP_MAX) exp_next = req.data[7:0];
        SEL_LOW_POWER: // Reserved and out of range ignored
          if (req.data[7:0] <= LOW_POWER_MAX
              && req.data[7:0] != LOW_POWER_RSVD) lp_next = req.data[7:0];
        SEL_DOZE:
          if (req.data[15:0] <= DOZE_MAX) doze_next = req.data[15:0];
        SEL_IDLE_WAIT: idle_next = req.data[15:0];
        SEL_PWM_HOLD: hold_next = req.data[7:0];
        default: ; // Identity words stay fixed
      endcase
    end
    case (req.sel)
      SEL_CHANNEL_MASK: rdd_next = {16'h0000, mask_reg};
      SEL_SURVEY_EXP: rdd_next = {24'h000000, exp_reg};
      SEL_UPPER_ID: rdd_next = UPPER_ID;
      SEL_LOWER_ID: rdd_next = LOWER_ID;
      SEL_LOW_POWER: rdd_next = {24'h000000, lp_reg};
      SEL_DOZE: rdd_next = {16'h0000, doze_reg};
      SEL_IDLE_WAIT: rdd_next = {16'h0000, idle_reg};
      SEL_FW_REV: rdd_next = {16'h0000, FW_REV};
      SEL_PWM_HOLD: rdd_next = {24'h000000, hold_reg};
      default: rdd_next = 32'h0000_0000;
    endcase
    if (!req.rd) rdd_next = rdd_reg;
  end

  // Register bank
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      mask_reg <= RST_CHANNEL_MASK;
      exp_reg <= RST_SURVEY_EXP;
      lp_reg <= RST_LOW_POWER;
      doze_reg <= RST_DOZE;
      idle_reg <= RST_IDLE_WAIT;
      hold_reg <= RST_PWM_HOLD;
      loaded_reg <= 1'b0;
      rdd_reg <= 32'h0000_0000;
      rdv_reg <= 1'b0;
    end
    else
    begin
      mask_reg <= mask_next;
      exp_reg <= exp_next;
      lp_reg <= lp_next;
      doze_reg <= doze_next;
      idle_reg <= idle_next;
      hold_reg <= hold_next;
      loaded_reg <= loaded_next;
      rdd_reg <= rdd_next;
      rdv_reg <= rdv_next;
    end
  end

  assign rd_data = rdd_reg;
  assign rd_valid = rdv_reg;
  assign save_image = {24'h000000, hold_reg, idle_reg, doze_reg, lp_reg,
                       exp_reg, mask_reg};
  assign save_strobe = commit;

  // Meter: duty steps from margin, hold timer, step counters
  logic [5:0] duty_reg, duty_next;        // High steps of forty
  logic [5:0] step_reg, step_next;
  logic [31:0] tick_reg, tick_next;
  logic [31:0] hold_cyc_reg, hold_cyc_next;
  logic [7:0] hold_cnt_reg, hold_cnt_next;
  logic pwm_reg, pwm_next;
  int unsigned pct_x10;
  always_comb
  begin
    // Percent times ten, then steps of 2.5 percent
    // One tenth of a percent kept so the step floor is not taken twice
    pct_x10 = ((DUTY_OFS_X10 + DUTY_SLOPE_X10 * int'(pkt_margin_db)) * 100)
              / DUTY_DIV_X100;
    duty_next = duty_reg;
    hold_cnt_next = hold_cnt_reg;
    hold_cyc_next = hold_cyc_reg;
    if (pkt_rx)
    begin
      duty_next = (pct_x10 * PWM_STEPS / 1000 > PWM_STEPS) ?
                  6'(PWM_STEPS) : 6'(pct_x10 * PWM_STEPS / 1000);
      hold_cnt_next = hold_reg;
      hold_cyc_next = 32'h0000_0000;
    end
    else if (hold_reg != PWM_HOLD_FOREVER && hold_reg != 8'h00
             && duty_reg != 6'h00)
    begin
      if (hold_cyc_reg >= 32'(HOLD_CYCLES - 1))
      begin
        hold_cyc_next = 32'h0000_0000;
        if (hold_cnt_reg <= 8'h01)
        begin
          duty_next = 6'h00; // Timeout drops duty
          hold_cnt_next = 8'h00;
        end
        else
          hold_cnt_next = hold_cnt_reg - 8'h01;
      end
      else
        hold_cyc_next = hold_cyc_reg + 32'h0000_0001;
    end
    tick_next = tick_reg + 32'h0000_0001;
    step_next = step_reg;
    if (tick_reg >= 32'(STEP_CYCLES - 1))
    begin
      tick_next = 32'h0000_0000;
      step_next = (step_reg == 6'(PWM_STEPS - 1)) ? 6'h00
                  : step_reg + 6'h01;
    end
    pwm_next = (step_reg < duty_reg);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      duty_reg <= 6'h00; // Zero duty until a packet
      step_reg <= 6'h00;
      tick_reg <= 32'h0000_0000;
      hold_cyc_reg <= 32'h0000_0000;
      hold_cnt_reg <= 8'h00;
      pwm_reg <= 1'b0;
    end
    else
    begin
      duty_reg <= duty_next;
      step_reg <= step_next;
      tick_reg <= tick_next;
      hold_cyc_reg <= hold_cyc_next;
      hold_cnt_reg <= hold_cnt_next;
      pwm_reg <= pwm_next;
    end
  end
  assign pwm_out = pwm_reg;

  // Scan sequencer, any scan kind walks masked channels
  logic [4:0] ch_reg, ch_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic [47:0] dwell_reg, dwell_next;
  always_comb
  begin
    ch_next = ch_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    dwell_next = dwell_reg;
    if (!busy_reg && scan_start)
    begin
      if (mask_reg == 16'h0000)
        done_next = 1'b1; // Empty mask
      else
      begin
        busy_next = 1'b1;
        ch_next = 5'h00;
        dwell_next = 48'h0;
      end
    end
    else if (busy_reg)
    begin
      if (!mask_reg[ch_reg[3:0]]) // Skip disabled
        dwell_next = 48'(SLOT_CYCLES) << exp_reg[3:0];
      else
        dwell_next = dwell_reg + 48'h1;
      if (dwell_next >= (48'(SLOT_CYCLES) << exp_reg[3:0]))
      begin
        dwell_next = 48'h0;
        if (ch_reg == 5'h0F)
        begin
          busy_next = 1'b0;
          done_next = 1'b1;
        end
        else
          ch_next = ch_reg + 5'h01;
      end
    end
  end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ch_reg <= 5'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      dwell_reg <= 48'h0;
    end
    else
    begin
      ch_reg <= ch_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      dwell_reg <= dwell_next;
    end
  end
  assign scan_channel = ch_reg + 5'h0B;
  assign scan_busy = busy_reg;
  assign scan_done = done_reg;

  // Sleep cycle and indirect hold timer
  sleep_state_t st_reg, st_next;
  logic [31:0] ms_reg, ms_next;
  logic [31:0] units_reg, units_next;
  logic [31:0] ind_reg, ind_next;
  logic ind_on_reg, ind_on_next, drop_reg, drop_next;
  logic ms_tick;
  assign cyclic = (lp_reg == LOW_POWER_CYC || lp_reg == LOW_POWER_CYC_PIN);
  assign ms_tick = (ms_reg >= 32'(MS_CYCLES - 1));
  always_comb
  begin
    ms_next = ms_tick ? 32'h0 : ms_reg + 32'h1;
    units_next = units_reg;
    st_next = st_reg;
    case (st_reg)
      SLP_AWAKE:
      begin
        if (activity || !cyclic) units_next = 32'h0;
        else if (ms_tick) units_next = units_reg + 32'h1;
        if (cyclic && units_reg >= 32'(idle_reg))
        begin
          st_next = SLP_DOZE;
          units_next = 32'h0;
        end
      end
      SLP_DOZE:
      begin
        if (ms_tick) units_next = units_reg + 32'h1;
        if (units_reg >= 32'(doze_reg) * 32'd10)
          st_next = SLP_CHECK;
      end
      SLP_CHECK:
      begin
        units_next = 32'h0;
        st_next = data_pending ? SLP_AWAKE : SLP_DOZE;
      end
      default: st_next = SLP_AWAKE;
    endcase
    // Indirect hold of 2.5 intervals, in ms: 25 per unit
    ind_on_next = ind_on_reg;
    ind_next = ind_reg;
    drop_next = 1'b0;
    if (indirect_start && is_coordinator && doze_reg != 16'h0000)
    begin
      ind_on_next = 1'b1;
      ind_next = 32'h0;
    end
    else if (ind_on_reg && ms_tick)
    begin
      ind_next = ind_reg + 32'h1;
      if (ind_reg + 32'h1 >= 32'(doze_reg) * 32'd25)
      begin
        drop_next = 1'b1;
        ind_on_next = 1'b0;
      end
    end
  end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= SLP_AWAKE;
      ms_reg <= 32'h0;
      units_reg <= 32'h0;
      ind_reg <= 32'h0;
      ind_on_reg <= 1'b0;
      drop_reg <= 1'b0;
    end
    else
    begin
      st_reg <= cyclic ? st_next : SLP_AWAKE;
      ms_reg <= ms_next;
      units_reg <= units_next;
      ind_reg <= ind_next;
      ind_on_reg <= ind_on_next;
      drop_reg <= drop_next;
    end
  end
  assign asleep = (st_reg == SLP_DOZE);
  assign indirect_drop = drop_reg;
  assign direct_delivery = (doze_reg == 16'h0000);
  assign pin_sleep_enable = (lp_reg == 8'h01 || lp_reg == 8'h02);
  assign pin_wake_enable = (lp_reg == LOW_POWER_CYC_PIN);

  // Checks
  read_id_a: assert property (@(posedge clock) disable iff (rst)
    req.rd && req.sel == SEL_UPPER_ID |=> rd_data == UPPER_ID)
    else $error("upper id read wrong");
  hold_off_a: assert property (@(posedge clock) disable iff (rst)
    hold_reg == PWM_HOLD_FOREVER && !pkt_rx |=> $stable(duty_reg))
    else $error("meter expired in forever mode");
  empty_scan_a: assert property (@(posedge clock) disable iff (rst)
    !busy_reg && scan_start && mask_reg == 16'h0 |=> scan_done)
    else $error("empty scan not immediate");
  no_sleep_a: assert property (@(posedge clock) disable iff (rst)
    !cyclic |=> !asleep)
    else $error("doze outside cyclic choice");
  // A channel held for more than one cycle must be enabled in the mask
  chan_map_a: assert property (@(posedge clock) disable iff (rst)
    scan_busy && $past(scan_busy) && $stable(scan_channel)
    |-> mask_reg[4'(scan_channel - 5'h0B)])
    else $error("dwell on disabled channel");
  step_max_a: assert property (@(posedge clock) disable iff (rst)
    step_reg < 6'(PWM_STEPS))
    else $error("step past forty");
  rsvd_lp_a: assert property (@(posedge clock) disable iff (rst)
    lp_reg != LOW_POWER_RSVD && lp_reg <= LOW_POWER_MAX)
    else $error("bad low power choice");
  commit_a: assert property (@(posedge clock) disable iff (rst)
    commit |-> save_strobe && save_image[15:0] == mask_reg)
    else $error("commit image wrong");
  // First cycle after reset takes the stored mask
  reload_a: assert property (@(posedge clock) disable iff (rst)
    !loaded_reg && load_valid |=> mask_reg == $past(load_image[15:0]))
    else $error("stored image not reloaded");
endmodule // rf_module_config_params

// ===== tb/rf_module_config_params_bench.sv
// Self-checking bench for the radio configuration bank
module rf_module_config_params_bench
  import rf_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] UP_ID = 32'hA5A5_0101; // Arbitrary value
  localparam logic [31:0] LO_ID = 32'h5A5A_0202; // Arbitrary value
  localparam logic [15:0] FW = 16'h1104; // Arbitrary value
  logic clock = 1'b0; // System clock
  logic rst = 1'b1; // Async reset
  cfg_req_t req = '0; // Command port
  logic commit = 1'b0, pkt_rx = 1'b0, scan_start = 1'b0, activity = 1'b0;
  logic data_pending = 1'b0, is_coordinator = 1'b0, indirect_start = 1'b0;
  logic [6:0] pkt_margin_db = 7'h00; // Packet margin
  logic rd_valid, save_strobe, load_valid, pwm_out, scan_busy, scan_done;
  logic indirect_drop, direct_delivery, asleep;
  logic pin_sleep_enable, pin_wake_enable;
  logic [31:0] rd_data; // Read answer
  logic [95:0] save_image, load_image; // Store images
  logic [4:0] scan_channel; // Scanned channel
  int err_count = 0; // Mismatches
  int comparisons = 0; // Compares made
  // Clock at 100 MHz
  always #5 clock = ~clock;
  // Device under test, long counts shortened
  rf_module_config_params #(.UPPER_ID(UP_ID), .LOWER_ID(LO_ID),
    .FW_REV(FW), .SLOT_CYCLES(10), .MS_CYCLES(4), .HOLD_CYCLES(8),
    .STEP_CYCLES(2)) u_rf_module_config_params (.clock(clock), .rst(rst),
    .req(req), .commit(commit), .rd_data(rd_data), .rd_valid(rd_valid),
    .save_image(save_image), .save_strobe(save_strobe),
    .load_image(load_image), .load_valid(load_valid), .pkt_rx(pkt_rx),
    .pkt_margin_db(pkt_margin_db), .pwm_out(pwm_out),
    .scan_start(scan_start), .scan_channel(scan_channel),
    .scan_busy(scan_busy), .scan_done(scan_done), .activity(activity),
    .data_pending(data_pending), .is_coordinator(is_coordinator),
    .indirect_start(indirect_start), .indirect_drop(indirect_drop),
    .direct_delivery(direct_delivery), .asleep(asleep),
    .pin_sleep_enable(pin_sleep_enable), .pin_wake_enable(pin_wake_enable));
  // Far-side store
  rf_store_model u_rf_store_model (.clock(clock), .save_image(save_image),
    .save_strobe(save_strobe), .load_image(load_image),
    .load_valid(load_valid));
  // Step to just after the next rising edge
  task automatic tick();
    @(posedge clock);
    #1;
  endtask
  // Compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic summarize();
    if (err_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One write cycle, then one idle edge
  task automatic wr(input logic [3:0] s, input logic [31:0] d);
    req = {1'b1, 1'b0, s, d};
    tick();
    req = '0;
    tick();
  endtask
  // One read cycle, answer one cycle later, then one idle edge
  task automatic rd(input logic [3:0] s, input logic [31:0] exp);
    req = {1'b0, 1'b1, s, 32'h0};
    tick();
    check({31'h0, rd_valid}, 32'h1);
    check(rd_data, exp);
    req = '0;
    tick();
  endtask
  // Write then read back
  task automatic wr_rd(input logic [3:0] s, input logic [31:0] d,
    input logic [31:0] exp);
    wr(s, d);
    rd(s, exp);
  endtask
  // Defaults after reset
  task automatic t_defaults();
    rd(SEL_CHANNEL_MASK, 32'h1FFE);
    rd(SEL_SURVEY_EXP, 32'h4);
    rd(SEL_UPPER_ID, UP_ID);
    rd(SEL_LOWER_ID, LO_ID);
    rd(SEL_LOW_POWER, 32'h0);
    rd(SEL_DOZE, 32'h0);
    rd(SEL_IDLE_WAIT, 32'h1388);
    rd(SEL_FW_REV, {16'h0, FW});
    check({31'h0, direct_delivery}, 32'h1);
  endtask
  // Read-only places and out-of-range values
  task automatic t_refusals();
    wr_rd(SEL_UPPER_ID, 32'hFFFF_FFFF, UP_ID);
    wr_rd(SEL_LOWER_ID, 32'h0, LO_ID);
    wr_rd(SEL_FW_REV, 32'h0, {16'h0, FW});
    wr_rd(SEL_SURVEY_EXP, 32'h10, 32'h4);
    wr_rd(SEL_SURVEY_EXP, 32'h0F, 32'h0F);
    wr_rd(SEL_LOW_POWER, 32'h3, 32'h0);
    wr_rd(SEL_LOW_POWER, 32'h6, 32'h0);
    wr_rd(SEL_DOZE, 32'h68B1, 32'h0);
    wr_rd(SEL_DOZE, 32'h68B0, 32'h68B0);
    check({31'h0, direct_delivery}, 32'h0);
    wr_rd(SEL_DOZE, 32'h0, 32'h0);
    check({31'h0, direct_delivery}, 32'h1);
  endtask
  // Low-power choice decode
  task automatic t_decode();
    logic [7:0] lp;
    for (int i = 0; i < 6; i++)
    begin
      lp = (i == 3) ? 8'h0 : 8'(i);
      wr_rd(SEL_LOW_POWER, {24'h0, lp}, {24'h0, lp});
      check({31'h0, pin_sleep_enable}, {31'h0, lp == 1 || lp == 2});
      check({31'h0, pin_wake_enable}, {31'h0, lp == 5});
    end
    wr(SEL_LOW_POWER, 32'h0);
  endtask
  // Scan with exponent 1: each enabled channel dwells 20 cycles
  task automatic t_scan(input logic [15:0] mask);
    int hits [32];
    int dones;
    hits = '{default: 0};
    dones = 0;
    wr(SEL_CHANNEL_MASK, {16'h0, mask});
    wr(SEL_SURVEY_EXP, 32'h1);
    scan_start = 1'b1;
    tick();
    scan_start = 1'b0;
    repeat (300)
    begin
      if (scan_busy === 1'b1)
        hits[scan_channel]++;
      if (scan_done === 1'b1)
        dones++;
      tick();
    end
    check(hits[5'h0B], mask[0] ? 20 : 0);
    check(hits[5'h1A], mask[15] ? 20 : 0);
    check(hits[5'h0C] <= 1, 1);
    check(dones, 1);
  endtask
  // Duty steps from margin
  function automatic int steps(input int db);
    return (2950 + 175 * db) * 4 / 1024;
  endfunction
  // High cycles over two meter periods
  task automatic meter(output int n);
    n = 0;
    repeat (160)
    begin
      n += (pwm_out === 1'b1);
      tick();
    end
  endtask
  // Packet arrival pulse
  task automatic pkt(input logic [6:0] db);
    pkt_rx = 1'b1;
    pkt_margin_db = db;
    tick();
    pkt_rx = 1'b0;
    repeat (10) tick();
  endtask
  // Signal strength meter
  task automatic t_meter();
    int n;
    meter(n);
    check(n, 0);
    pkt(7'd10);
    meter(n);
    check(n, steps(10) * 4);
    pkt(7'd30);
    meter(n);
    check(n, steps(30) * 4);
    wr(SEL_PWM_HOLD, 32'h1);
    pkt(7'd20);
    repeat (40) tick();
    meter(n);
    check(n, 0);
    wr(SEL_PWM_HOLD, {24'h0, PWM_HOLD_FOREVER});
    pkt(7'd20);
    repeat (600) tick();
    meter(n);
    check(n, steps(20) * 4);
  endtask
  // Wait up to a bound for asleep to reach a level
  task automatic wait_sleep(input logic lvl, input int lim);
    int k;
    k = 0;
    while (asleep !== lvl && k < lim)
    begin
      tick();
      k++;
    end
    check({31'h0, asleep}, {31'h0, lvl});
  endtask
  // Idle wait then cyclic doze
  task automatic t_sleep();
    check({31'h0, asleep}, 32'h0);
    wr(SEL_IDLE_WAIT, 32'h2);
    wr(SEL_DOZE, 32'h2);
    wr(SEL_LOW_POWER, {24'h0, LOW_POWER_CYC});
    activity = 1'b1;
    repeat (30) tick();
    check({31'h0, asleep}, 32'h0);
    activity = 1'b0;
    wait_sleep(1'b1, 30);
    wait_sleep(1'b0, 200);
    wait_sleep(1'b1, 40);
    // Data found at the wake check keeps the module awake
    data_pending = 1'b1;
    wait_sleep(1'b0, 200);
    repeat (3) tick();
    check({31'h0, asleep}, 32'h0);
    data_pending = 1'b0;
    wr(SEL_LOW_POWER, 32'h0);
    repeat (100) tick();
    check({31'h0, asleep}, 32'h0);
  endtask
  // Indirect hold: 2.5 intervals of 10 ms, 4 cycles per ms here
  task automatic t_indirect();
    int k;
    wr(SEL_DOZE, 32'h1);
    is_coordinator = 1'b1;
    indirect_start = 1'b1;
    tick();
    indirect_start = 1'b0;
    k = 0;
    while (indirect_drop !== 1'b1 && k < 150)
    begin
      tick();
      k++;
    end
    check({31'h0, k > 96 && k <= 100}, 32'h1);
    // End devices hold nothing
    is_coordinator = 1'b0;
    indirect_start = 1'b1;
    tick();
    indirect_start = 1'b0;
    k = 0;
    repeat (150)
    begin
      k += (indirect_drop === 1'b1);
      tick();
    end
    check(k, 0);
    wr(SEL_DOZE, 32'h0);
  endtask
  // Commit, change, then power cycle
  task automatic t_commit();
    wr(SEL_CHANNEL_MASK, 32'h00F0);
    commit = 1'b1;
    #1;
    check({31'h0, save_strobe}, 32'h1);
    check({16'h0, save_image[15:0]}, 32'h00F0);
    tick(); // Nothing else sent during the save
    commit = 1'b0;
    wr(SEL_CHANNEL_MASK, 32'h0F00);
    rst = 1'b1;
    repeat (2) tick();
    rst = 1'b0;
    repeat (2) tick();
    rd(SEL_CHANNEL_MASK, 32'h00F0);
    rd(SEL_SURVEY_EXP, 32'h1);
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clock);
    #1;
    rst = 1'b0;
    tick();
    t_defaults();
    t_refusals();
    t_decode();
    t_scan(16'h8001);
    t_scan(16'h0000);
    t_meter();
    t_sleep();
    t_indirect();
    t_commit();
    summarize();
  end
  // Watchdog against a hang
  initial
  begin
    #200000;
    err_count++;
    summarize();
  end
endmodule // rf_module_config_params_bench

// ===== tb/rf_store_model.sv
// Non-volatile store model holding the last committed image
module rf_store_model
(
  input wire logic clock,
  input wire logic [95:0] save_image,
  input wire logic save_strobe,
  output logic [95:0] load_image,
  output logic load_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [95:0] kept_reg = '0; // Last saved image, survives device reset
  logic kept_valid_reg = 1'b0; // Set once anything was saved
  // Capture the image on a save pulse
  always @(posedge clock)
  begin
    if (save_strobe)
    begin
      kept_reg <= save_image;
      kept_valid_reg <= 1'b1;
    end
  end
  // Empty store shows the inverse, never a plausible image
  assign load_image = kept_valid_reg ? kept_reg : ~kept_reg;
  assign load_valid = kept_valid_reg;
endmodule // rf_store_model
